// *** hmr_pkg.sv ***
// Shared constants and types for the haptic mode and real-time input block.
// Assumes a single 20 MHz system clock and the serial register bus on two pins.
package hmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_RTP = 8'h02;
  localparam logic [7:0] RTP_RST = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [2:0] RESV_ZERO = 3'h0;
  localparam logic [7:0] PTR_STEP = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Drive and soft reset
  localparam logic [7:0] SIGN_FLIP = 8'h80;
  localparam logic [7:0] LEVEL_IDLE = 8'h00;
  localparam int SRST_W = 3;
  localparam logic [SRST_W-1:0] SRST_CYCLES = 3'h4;
  localparam logic [SRST_W-1:0] SRST_LAST = 3'h1;
  localparam logic [SRST_W-1:0] SRST_IDLE = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Serial bus
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a; // Arbitrary value

  typedef enum logic [2:0] {
    HMR_MODE_INTERNAL = 3'h0,
    HMR_MODE_EDGE = 3'h1,
    HMR_MODE_LEVEL = 3'h2,
    HMR_MODE_PWM_ANALOG = 3'h3,
    HMR_MODE_AUDIO = 3'h4,
    HMR_MODE_REALTIME = 3'h5,
    HMR_MODE_DIAG = 3'h6,
    HMR_MODE_AUTOCAL = 3'h7
  } hmr_mode_t;

  typedef struct packed {
    logic soft_device_reset;
    logic standby;
    logic [2:0] resv;
    hmr_mode_t mode;
  } hmr_mode_reg_t;

  localparam hmr_mode_reg_t MODE_REG_RST = '{soft_device_reset: 1'b0, standby: 1'b1,
                                             resv: RESV_ZERO, mode: HMR_MODE_INTERNAL};

  typedef enum logic [3:0] {
    HMR_BUS_IDLE, HMR_BUS_ADDR, HMR_BUS_ACK_ADDR, HMR_BUS_REG, HMR_BUS_ACK_REG,
    HMR_BUS_WDATA, HMR_BUS_ACK_W, HMR_BUS_RDATA, HMR_BUS_RACK
  } hmr_bus_st_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic trig;
  } hmr_pins_t;

  localparam hmr_pins_t PINS_RST = '{scl: 1'b1, sda: 1'b1, trig: 1'b0};

  typedef struct packed {
    hmr_bus_st_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    hmr_pins_t prev;
    hmr_mode_reg_t mode_reg;
    logic [7:0] realtime_playback;
    logic [SRST_W-1:0] srst_cnt;
    logic go;
    logic cancel;
    logic fail;
    logic [7:0] level;
  } hmr_state_t;

  localparam hmr_state_t STATE_RST = '{st: HMR_BUS_IDLE, cnt: CNT_ZERO, shreg: RD_UNMAPPED,
                                       tx: RD_UNMAPPED, ptr: RD_UNMAPPED, rw: 1'b0,
                                       sda_oe: 1'b0, prev: PINS_RST, mode_reg: MODE_REG_RST,
                                       realtime_playback: RTP_RST, srst_cnt: SRST_IDLE, go: 1'b0,
                                       cancel: 1'b0, fail: 1'b0, level: LEVEL_IDLE};

endpackage

// *** hmr_sync.sv ***
// Two-stage synchroniser for a group of pins.
// Assumes inputs asynchronous to clk_i; reset value chosen per instance.
`timescale 1ns/1ps
module hmr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } hmr_sync_st_t;

  hmr_sync_st_t st_ff;
  hmr_sync_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops, first read only by the second
  always_comb begin
    nxt_st.meta = d_i;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_ff <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.sync;

endmodule // hmr_sync

// *** hmr_mode_ctrl.sv ***
// Mode and real-time input registers with their serial register bus slave.
// Assumes the go set strobe, playback engine and format bits live elsewhere on SYS_CLK_I.
//
// Contract
// - Writing one to mode bit 7 starts a full internal soft reset.
// - Soft reset aborts playback at once and restores every register default.
// - Soft reset bit clears itself when the reset finishes; reads then give zero.
// - Standby bit 6 resets to one; clearing it makes the device ready.
// - Mode 0: playback starts only when software sets the go bit.
// - Mode 1: a rising trigger edge while go is clear sets the go bit.
// - Mode 1: rising edge while go is set cancels the waveform.
// - Mode 2: go follows trigger; rise sets it, fall cancels.
// - Mode 2: an edge matching the current go state changes nothing.
// - Mode 3: trigger pin is the drive source, actuator driven throughout.
// - Mode 3: analog select bit picks pulse-width or analog treatment.
// - Mode 5: actuator driven continuously from the real-time value.
// - Mode 6: host sets go; device clears it at end, stores fail flag.
// - Mode 7: host loads parameters, sets go; device clears go when done.
// - Real-time value is 8 bits, driven to the load only in mode 5.
// - Host rewrites of the real-time value apply as they arrive.
// - Real-time value is signed unless the format bit selects unsigned.
`timescale 1ns/1ps
module hmr_mode_ctrl #(
  parameter logic [6:0] DEV_ADDR = hmr_pkg::DEV_ADDR_DFLT
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  // Serial register bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Trigger pin
  input wire logic TRIG_I,
  // Neighbouring registers and playback engine
  input wire logic GO_SET_I,
  input wire logic ENGINE_DONE_I,
  input wire logic ENGINE_FAIL_I,
  input wire logic ANALOG_SEL_I,
  input wire logic UNSIGNED_FMT_I,
  // Mode state
  output logic [2:0] MODE_O,
  output logic STANDBY_O,
  output logic SOFT_RESET_O,
  output logic GO_O,
  output logic CANCEL_O,
  output logic ROUTINE_FAIL_O,
  // Drive control
  output logic CONT_DRIVE_O,
  output logic PIN_SOURCE_O,
  output logic SRC_ANALOG_O,
  output logic RT_DRIVE_O,
  output logic [7:0] DRIVE_LEVEL_O
);

  hmr_pkg::hmr_state_t st_ff;
  hmr_pkg::hmr_state_t nxt_st;
  hmr_pkg::hmr_pins_t pins;
  hmr_pkg::hmr_mode_reg_t wr_mode;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic trig_rise;
  logic trig_fall;
  logic wr_stb;
  logic srst_req;
  logic busy;
  logic go_set;
  logic go_clr;
  logic rt_en;
  logic cont_en;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  hmr_sync #(
    .W(3),
    .RST_VAL(hmr_pkg::PINS_RST)
  ) u_pin_sync (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({SCL_I, SDA_I, TRIG_I}),
    .q_o(pins)
  );

  assign scl_rise = pins.scl & ~st_ff.prev.scl;
  assign scl_fall = ~pins.scl & st_ff.prev.scl;
  assign bus_start = pins.scl & st_ff.prev.scl & st_ff.prev.sda & ~pins.sda;
  assign bus_stop = pins.scl & st_ff.prev.scl & ~st_ff.prev.sda & pins.sda;
  assign trig_rise = pins.trig & ~st_ff.prev.trig;
  assign trig_fall = ~pins.trig & st_ff.prev.trig;
  assign busy = st_ff.mode_reg.soft_device_reset;

  function automatic logic [7:0] rd_mux(input hmr_pkg::hmr_state_t s, input logic [7:0] a);
    logic [7:0] d;
    d = hmr_pkg::RD_UNMAPPED;
    if (a == hmr_pkg::REG_MODE) begin
      d = s.mode_reg;
    end else if (a == hmr_pkg::REG_RTP) begin
      d = s.realtime_playback;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    wr_stb = 1'b0;
    go_set = 1'b0;
    go_clr = 1'b0;
    nxt_st.cancel = 1'b0;
    nxt_st.prev = pins;
    wr_mode = hmr_pkg::hmr_mode_reg_t'(st_ff.shreg);

    // Bus slave
    if (bus_start) begin
      nxt_st.st = hmr_pkg::HMR_BUS_ADDR;
      nxt_st.cnt = hmr_pkg::CNT_ZERO;
    end else if (bus_stop) begin
      nxt_st.st = hmr_pkg::HMR_BUS_IDLE;
    end else if (scl_rise) begin
      case (st_ff.st)
        hmr_pkg::HMR_BUS_ADDR, hmr_pkg::HMR_BUS_REG, hmr_pkg::HMR_BUS_WDATA: begin
          nxt_st.shreg = {st_ff.shreg[6:0], pins.sda};
          nxt_st.cnt = 4'(st_ff.cnt + hmr_pkg::CNT_STEP);
        end
        hmr_pkg::HMR_BUS_RDATA: begin
          nxt_st.cnt = 4'(st_ff.cnt + hmr_pkg::CNT_STEP);
        end
        hmr_pkg::HMR_BUS_RACK: begin
          if (pins.sda) begin
            nxt_st.st = hmr_pkg::HMR_BUS_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_ff.st)
        hmr_pkg::HMR_BUS_ADDR: begin
          if (st_ff.cnt == hmr_pkg::BITS_PER_BYTE) begin
            nxt_st.cnt = hmr_pkg::CNT_ZERO;
            nxt_st.rw = st_ff.shreg[0];
            nxt_st.st = (st_ff.shreg[7:1] == DEV_ADDR) ? hmr_pkg::HMR_BUS_ACK_ADDR : hmr_pkg::HMR_BUS_IDLE;
          end
        end
        hmr_pkg::HMR_BUS_ACK_ADDR: begin
          if (st_ff.rw) begin
            nxt_st.st = hmr_pkg::HMR_BUS_RDATA;
            nxt_st.tx = rd_mux(st_ff, st_ff.ptr);
          end else begin
            nxt_st.st = hmr_pkg::HMR_BUS_REG;
          end
        end
        hmr_pkg::HMR_BUS_REG: begin
          if (st_ff.cnt == hmr_pkg::BITS_PER_BYTE) begin
            nxt_st.cnt = hmr_pkg::CNT_ZERO;
            nxt_st.ptr = st_ff.shreg;
            nxt_st.st = hmr_pkg::HMR_BUS_ACK_REG;
          end
        end
        hmr_pkg::HMR_BUS_ACK_REG: begin
          nxt_st.st = hmr_pkg::HMR_BUS_WDATA;
        end
        hmr_pkg::HMR_BUS_WDATA: begin
          if (st_ff.cnt == hmr_pkg::BITS_PER_BYTE) begin
            nxt_st.cnt = hmr_pkg::CNT_ZERO;
            wr_stb = 1'b1;
            nxt_st.st = hmr_pkg::HMR_BUS_ACK_W;
          end
        end
        hmr_pkg::HMR_BUS_ACK_W: begin
          nxt_st.ptr = 8'(st_ff.ptr + hmr_pkg::PTR_STEP);
          nxt_st.st = hmr_pkg::HMR_BUS_WDATA;
        end
        hmr_pkg::HMR_BUS_RDATA: begin
          if (st_ff.cnt == hmr_pkg::BITS_PER_BYTE) begin
            nxt_st.cnt = hmr_pkg::CNT_ZERO;
            nxt_st.st = hmr_pkg::HMR_BUS_RACK;
          end else begin
            nxt_st.tx = {st_ff.tx[6:0], 1'b0};
          end
        end
        hmr_pkg::HMR_BUS_RACK: begin
          nxt_st.ptr = 8'(st_ff.ptr + hmr_pkg::PTR_STEP);
          nxt_st.tx = rd_mux(st_ff, 8'(st_ff.ptr + hmr_pkg::PTR_STEP));
          nxt_st.st = hmr_pkg::HMR_BUS_RDATA;
        end
        default: begin
        end
      endcase
    end
    nxt_st.sda_oe = (nxt_st.st == hmr_pkg::HMR_BUS_ACK_ADDR) || (nxt_st.st == hmr_pkg::HMR_BUS_ACK_REG) ||
                    (nxt_st.st == hmr_pkg::HMR_BUS_ACK_W) ||
                    ((nxt_st.st == hmr_pkg::HMR_BUS_RDATA) && !nxt_st.tx[7]);

    // Register writes and soft reset
    srst_req = wr_stb && (st_ff.ptr == hmr_pkg::REG_MODE) && wr_mode.soft_device_reset;
    if (srst_req) begin
      nxt_st.mode_reg = hmr_pkg::MODE_REG_RST;
      nxt_st.mode_reg.soft_device_reset = 1'b1;
      nxt_st.realtime_playback = hmr_pkg::RTP_RST;
      nxt_st.go = 1'b0;
      nxt_st.cancel = st_ff.go;
      nxt_st.fail = 1'b0;
      nxt_st.srst_cnt = hmr_pkg::SRST_CYCLES;
    end else if (busy) begin
      nxt_st.srst_cnt = SRST_W_DEC(st_ff.srst_cnt);
      if (st_ff.srst_cnt == hmr_pkg::SRST_LAST) begin
        nxt_st.mode_reg.soft_device_reset = 1'b0;
      end
    end else begin
      if (wr_stb && (st_ff.ptr == hmr_pkg::REG_MODE)) begin
        nxt_st.mode_reg.standby = wr_mode.standby;
        nxt_st.mode_reg.resv = hmr_pkg::RESV_ZERO;
        nxt_st.mode_reg.mode = wr_mode.mode;
      end
      if (wr_stb && (st_ff.ptr == hmr_pkg::REG_RTP)) begin
        nxt_st.realtime_playback = st_ff.shreg;
      end

      // Go bit
      case (st_ff.mode_reg.mode)
        hmr_pkg::HMR_MODE_INTERNAL, hmr_pkg::HMR_MODE_DIAG, hmr_pkg::HMR_MODE_AUTOCAL: begin
          go_set = GO_SET_I;
        end
        hmr_pkg::HMR_MODE_EDGE: begin
          if (trig_rise && st_ff.go) begin
            go_clr = 1'b1;
            nxt_st.cancel = 1'b1;
          end else if (trig_rise) begin
            go_set = 1'b1;
          end
        end
        hmr_pkg::HMR_MODE_LEVEL: begin
          if (trig_rise && !st_ff.go) begin
            go_set = 1'b1;
          end
          if (trig_fall && st_ff.go) begin
            go_clr = 1'b1;
            nxt_st.cancel = 1'b1;
          end
        end
        default: begin
        end
      endcase
      if (ENGINE_DONE_I && st_ff.go && ((st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_DIAG) ||
                                        (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_AUTOCAL))) begin
        nxt_st.fail = ENGINE_FAIL_I;
      end
      nxt_st.go = go_set | (st_ff.go & ~go_clr & ~ENGINE_DONE_I);
    end

    // Drive level, offset binary at the load
    if (rt_en) begin
      nxt_st.level = UNSIGNED_FMT_I ? st_ff.realtime_playback : (st_ff.realtime_playback ^ hmr_pkg::SIGN_FLIP);
    end else begin
      nxt_st.level = hmr_pkg::LEVEL_IDLE;
    end
  end

  function automatic logic [hmr_pkg::SRST_W-1:0] SRST_W_DEC(input logic [hmr_pkg::SRST_W-1:0] c);
    return (c == hmr_pkg::SRST_IDLE) ? hmr_pkg::SRST_IDLE : hmr_pkg::SRST_W'(c - hmr_pkg::SRST_LAST);
  endfunction

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      st_ff <= hmr_pkg::STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rt_en = !busy && !st_ff.mode_reg.standby && (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_REALTIME);
  assign cont_en = !busy && !st_ff.mode_reg.standby &&
                   ((st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_PWM_ANALOG) ||
                    (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_AUDIO) ||
                    (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_REALTIME));

  assign SDA_O = 1'b0;
  assign SDA_OE_O = st_ff.sda_oe;
  assign MODE_O = st_ff.mode_reg.mode;
  assign STANDBY_O = st_ff.mode_reg.standby;
  assign SOFT_RESET_O = busy;
  assign GO_O = st_ff.go;
  assign CANCEL_O = st_ff.cancel;
  assign ROUTINE_FAIL_O = st_ff.fail;
  assign CONT_DRIVE_O = cont_en;
  assign PIN_SOURCE_O = cont_en && (st_ff.mode_reg.mode != hmr_pkg::HMR_MODE_REALTIME);
  assign SRC_ANALOG_O = ANALOG_SEL_I;
  assign RT_DRIVE_O = rt_en;
  assign DRIVE_LEVEL_O = st_ff.level;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  localparam int SRST_WAIT = 4;

  sequence s_quiet;
    !busy && !srst_req;
  endsequence

  sequence s_edge_rise_idle;
    s_quiet ##0 (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_EDGE) && trig_rise && !st_ff.go;
  endsequence

  sequence s_edge_rise_busy;
    s_quiet ##0 (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_EDGE) && trig_rise && st_ff.go;
  endsequence

  sequence s_level_fall_go;
    s_quiet ##0 (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_LEVEL) && trig_fall && st_ff.go;
  endsequence

  a_srst_load: assert property (srst_req |=> busy && st_ff.mode_reg.standby && !st_ff.go &&
                                (st_ff.realtime_playback == hmr_pkg::RTP_RST) && (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_INTERNAL))
    else $error("soft reset did not restore defaults");

  a_srst_selfclr: assert property (srst_req ##1 !srst_req [*4] |-> ##[0:SRST_WAIT] !busy)
    else $error("soft reset bit did not clear");

  a_srst_hold: assert property (disable iff (!RSTN_I) srst_req |=> busy [*3])
    else $error("soft reset ended too early");

  a_edge_set: assert property (s_edge_rise_idle |=> st_ff.go && !st_ff.cancel)
    else $error("edge trigger did not set go");

  a_edge_cancel: assert property (s_edge_rise_busy |=> !st_ff.go && st_ff.cancel)
    else $error("second edge did not cancel");

  a_level_fall: assert property (s_level_fall_go |=> !st_ff.go && st_ff.cancel)
    else $error("level fall did not cancel");

  a_level_noop: assert property (s_quiet ##0 (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_LEVEL) &&
                                 trig_rise && st_ff.go && !ENGINE_DONE_I |=> st_ff.go && !st_ff.cancel)
    else $error("level edge changed matching go");

  a_diag_done: assert property (s_quiet ##0 (st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_DIAG) &&
                                st_ff.go && ENGINE_DONE_I && !GO_SET_I |=>
                                !st_ff.go && $past(ENGINE_FAIL_I) == st_ff.fail)
    else $error("diagnostic end not recorded");

  a_rt_level: assert property (rt_en && UNSIGNED_FMT_I |=> DRIVE_LEVEL_O == $past(st_ff.realtime_playback))
    else $error("real-time level wrong");

  a_rt_signed: assert property (rt_en && !UNSIGNED_FMT_I |=>
                                DRIVE_LEVEL_O == ($past(st_ff.realtime_playback) ^ hmr_pkg::SIGN_FLIP))
    else $error("signed real-time level wrong");

  a_rt_idle: assert property (!rt_en |=> DRIVE_LEVEL_O == hmr_pkg::LEVEL_IDLE)
    else $error("level driven outside real-time mode");

  a_resv_zero: assert property (st_ff.mode_reg.resv == hmr_pkg::RESV_ZERO)
    else $error("reserved mode bits not zero");

  a_cont_drive: assert property ((st_ff.mode_reg.mode == hmr_pkg::HMR_MODE_PWM_ANALOG) && !busy &&
                                 !st_ff.mode_reg.standby |-> CONT_DRIVE_O && PIN_SOURCE_O)
    else $error("pin source not driving");

endmodule // hmr_mode_ctrl

// *** hmr_host_model.sv ***
// Host processor model: master on the serial register bus.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module hmr_host_model #(
  parameter logic [6:0] ADDR = hmr_pkg::DEV_ADDR_DFLT
) (
  // Clock
  input wire logic clk_i,
  // Bus pins
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i,
  // Results seen by the host
  output logic res_v_o,
  output logic [7:0] res_d_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    res_v_o = 1'b0;
    res_d_o = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Low phase, clears a pending result strobe
  task automatic low_wait;
    tick(1);
    res_v_o <= 1'b0;
    tick(3);
  endtask

  // One bit: 6 clocks low, 2 high, 400 ns
  task automatic bit_io(input logic b, output logic r);
    low_wait();
    sda_oe_o <= ~b;
    tick(2);
    scl_o <= 1'b1;
    tick(1);
    r = sda_i;
    tick(1);
    scl_o <= 1'b0;
  endtask

  task automatic start_cond;
    tick(2);
    sda_oe_o <= 1'b1;
    tick(2);
    scl_o <= 1'b0;
  endtask

  task automatic stop_cond;
    low_wait();
    sda_oe_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_oe_o <= 1'b0;
    tick(4);
  endtask

  // Byte MSB first, then acknowledge slot
  task automatic put_byte(input logic [7:0] d, input logic rd, input logic last);
    logic [7:0] v;
    logic r;
    v = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd | d[i], r);
      v = {v[6:0], r};
    end
    bit_io(~rd | last, r);
    res_d_o <= rd ? v : {7'h00, r};
    res_v_o <= 1'b1;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    start_cond();
    put_byte({a, 1'b0}, 1'b0, 1'b0);
    put_byte(p, 1'b0, 1'b0);
    put_byte(d, 1'b0, 1'b0);
    stop_cond();
  endtask

  task automatic read_reg(input logic [7:0] p);
    start_cond();
    put_byte({ADDR, 1'b0}, 1'b0, 1'b0);
    put_byte(p, 1'b0, 1'b0);
    stop_cond();
    start_cond();
    put_byte({ADDR, 1'b1}, 1'b0, 1'b0);
    put_byte(8'h00, 1'b1, 1'b1);
    stop_cond();
  endtask
endmodule // hmr_host_model

// *** tb_top.sv ***
// Self-checking bench for the mode and real-time input registers.
// Assumes hmr_host_model as bus master and a pull-up on the data line.
`timescale 1ns/1ps
module tb_top;
  typedef struct {string nm; logic [25:0] v;} hmr_note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic trig = 1'b0, go_set = 1'b0, done = 1'b0, fail_in = 1'b0, an = 1'b0, fmt = 1'b0;
  logic sda_o, sda_oe, standby, srst, go, cancel, rfail, cont, pins, ana_o, rt;
  logic [2:0] mode_o;
  logic [7:0] lvl, res_d, rv;
  logic scl, h_oe, res_v, sda_w;
  logic snap_v = 1'b0;
  logic [3:0] n_cancel = 4'h0, n_srst = 4'h0, exp_cc = 4'h0, exp_sr = 4'h0;
  logic [31:0] seed = 32'h76aa;
  logic [25:0] got;
  hmr_note_t notes[$];
  hmr_note_t n;
  int failures = 0;
  int n_tests = 0;

  always #25 clk = ~clk;
  assign sda_w = ~((sda_oe & ~sda_o) | h_oe);

  hmr_mode_ctrl hmr_mode_ctrl_inst (.SYS_CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .TRIG_I(trig), .GO_SET_I(go_set), .ENGINE_DONE_I(done), .ENGINE_FAIL_I(fail_in),
    .ANALOG_SEL_I(an), .UNSIGNED_FMT_I(fmt), .MODE_O(mode_o), .STANDBY_O(standby), .SOFT_RESET_O(srst),
    .GO_O(go), .CANCEL_O(cancel), .ROUTINE_FAIL_O(rfail), .CONT_DRIVE_O(cont), .PIN_SOURCE_O(pins),
    .SRC_ANALOG_O(ana_o), .RT_DRIVE_O(rt), .DRIVE_LEVEL_O(lvl));
  hmr_host_model hmr_host_model_inst (.clk_i(clk), .scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda_w),
    .res_v_o(res_v), .res_d_o(res_d));

  ////////////////////////////////////////////////////////////////////////////
  // Monitor
  always @(posedge clk) begin
    if (cancel === 1'b1) n_cancel <= n_cancel + 4'h1;
    if (srst === 1'b1) n_srst <= n_srst + 4'h1;
    if (res_v === 1'b1 || snap_v === 1'b1) begin
      got = (res_v === 1'b1) ? {18'h0, res_d} :
        {n_cancel, n_srst, mode_o, standby, go, rfail, cont, pins, rt, ana_o, lvl};
      n_tests++;
      if (notes.size() == 0) begin
        failures++;
        $display("unexpected result, nothing noted, seen %h", got);
      end else begin
        n = notes.pop_front();
        if (got !== n.v) begin
          failures++;
          $display("unexpected %s: expected %h, seen %h", n.nm, n.v, got);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [2:0] md, input logic sb, input logic g, input logic f);
    logic r;
    r = (md == 3'h5) & ~sb;
    notes.push_back('{nm, {exp_cc, exp_sr, md, sb, g, f, (md >= 3'h3) & (md <= 3'h5) & ~sb,
      (md == 3'h3 || md == 3'h4) & ~sb, r, an, r ? (fmt ? rv : rv ^ hmr_pkg::SIGN_FLIP) : 8'h00}});
    snap_v <= 1'b1;
    @(posedge clk);
    snap_v <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    repeat (3) notes.push_back('{"ack", 26'h0});
    hmr_host_model_inst.write_reg(hmr_pkg::DEV_ADDR_DFLT, p, d);
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    repeat (3) notes.push_back('{"ack", 26'h0});
    notes.push_back('{"read", {18'h0, e}});
    hmr_host_model_inst.read_reg(p);
  endtask

  task automatic pin(input logic v, input int w);
    if (w == 0) trig <= v;
    if (w == 1) go_set <= v;
    if (w == 2) done <= v;
    @(posedge clk);
    if (w != 0) begin
      go_set <= 1'b0;
      done <= 1'b0;
    end
    repeat (7) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    rv = 8'h00;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("defaults", 3'h0, 1'b1, 1'b0, 1'b0);
    rd(hmr_pkg::REG_MODE, 8'h40);
    wr(hmr_pkg::REG_MODE, 8'h3d);
    rd(hmr_pkg::REG_MODE, 8'h05);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      fmt <= seed[8];
      rv = seed[7:0];
      wr(hmr_pkg::REG_RTP, rv);
      chk("drive", 3'h5, 1'b0, 1'b0, 1'b0);
    end
    rd(hmr_pkg::REG_RTP, rv);
    wr(8'h10, 8'hff);
    rd(8'h10, hmr_pkg::RD_UNMAPPED);
    repeat (3) notes.push_back('{"nack", 26'h1});
    hmr_host_model_inst.write_reg(~hmr_pkg::DEV_ADDR_DFLT, hmr_pkg::REG_RTP, 8'h00);
    rd(hmr_pkg::REG_RTP, rv);
    wr(hmr_pkg::REG_MODE, 8'h45);
    chk("standby", 3'h5, 1'b1, 1'b0, 1'b0);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      seed = xs(seed);
      an <= seed[0] | (m == 4);
      wr(hmr_pkg::REG_MODE, {5'h00, 3'(m)});
      chk("mode", 3'(m), 1'b0, 1'b0, 1'b0);
    end
    $display("test modes done");
    wr(hmr_pkg::REG_MODE, 8'h00);
    pin(1'b1, 0);
    chk("go internal", 3'h0, 1'b0, 1'b0, 1'b0);
    pin(1'b0, 0);
    pin(1'b1, 1);
    chk("go internal", 3'h0, 1'b0, 1'b1, 1'b0);
    pin(1'b1, 2);
    wr(hmr_pkg::REG_MODE, 8'h01);
    pin(1'b1, 0);
    chk("go edge", 3'h1, 1'b0, 1'b1, 1'b0);
    pin(1'b0, 0);
    pin(1'b1, 0);
    exp_cc = exp_cc + 4'h1;
    chk("go edge cancel", 3'h1, 1'b0, 1'b0, 1'b0);
    pin(1'b0, 0);
    wr(hmr_pkg::REG_MODE, 8'h02);
    pin(1'b1, 0);
    chk("go level", 3'h2, 1'b0, 1'b1, 1'b0);
    pin(1'b0, 0);
    exp_cc = exp_cc + 4'h1;
    chk("go level cancel", 3'h2, 1'b0, 1'b0, 1'b0);
    pin(1'b1, 0);
    pin(1'b1, 2);
    pin(1'b0, 0);
    chk("go level same", 3'h2, 1'b0, 1'b0, 1'b0);
    wr(hmr_pkg::REG_MODE, 8'h00);
    pin(1'b1, 1);
    wr(hmr_pkg::REG_MODE, 8'h02);
    pin(1'b1, 0);
    chk("go level held", 3'h2, 1'b0, 1'b1, 1'b0);
    $display("test triggers done");
    wr(hmr_pkg::REG_MODE, 8'h06);
    pin(1'b1, 1);
    chk("diag go", 3'h6, 1'b0, 1'b1, 1'b0);
    fail_in <= 1'b1;
    pin(1'b1, 2);
    chk("diag end", 3'h6, 1'b0, 1'b0, 1'b1);
    wr(hmr_pkg::REG_MODE, 8'h07);
    fail_in <= 1'b0;
    pin(1'b1, 1);
    chk("cal go", 3'h7, 1'b0, 1'b1, 1'b1);
    pin(1'b1, 2);
    chk("cal end", 3'h7, 1'b0, 1'b0, 1'b0);
    $display("test routines done");
    pin(1'b1, 1);
    wr(hmr_pkg::REG_RTP, 8'h5a);
    wr(hmr_pkg::REG_MODE, 8'h85);
    exp_cc = exp_cc + 4'h1;
    exp_sr = exp_sr + {1'b0, hmr_pkg::SRST_CYCLES};
    chk("soft reset", 3'h0, 1'b1, 1'b0, 1'b0);
    rd(hmr_pkg::REG_MODE, 8'h40);
    rd(hmr_pkg::REG_RTP, hmr_pkg::RTP_RST);
    $display("test soft reset done");
    repeat (4) @(posedge clk);
    if (notes.size() != 0) begin
      failures++;
      $display("unexpected pending notes: expected 0, seen %0d", notes.size());
    end
    complete_run();
  end
endmodule // tb_top
